// [hdl/dsrp_link.sv]
`timescale 1ns/1ns
module dsrp_link (
	// Output clock pair, one edge per half cycle
	input wire logic link_clk,
	input wire logic rst_n,
	// Events toward the core
	dsrp_link_if.src ev
);
	logic rst_meta_reg;
	logic rst_ok_reg;
	logic c_phase_reg;

	// ----------------------------------------
	// Local reset release
	// ----------------------------------------
	always_ff @(posedge link_clk) begin
		rst_meta_reg <= rst_n;
		rst_ok_reg <= rst_meta_reg;
	end

	// ----------------------------------------
	// Positive and negative output clock edges as toggles
	// ----------------------------------------
	always_ff @(posedge link_clk) begin
		if (!rst_ok_reg) begin
			c_phase_reg <= dsrp_pkg::PHASE_RST;
			ev.pos_tgl <= 1'b0;
			ev.neg_tgl <= 1'b0;
		end else begin
			c_phase_reg <= ~c_phase_reg;
			if (!c_phase_reg) begin
				ev.pos_tgl <= ~ev.pos_tgl;
			end else begin
				ev.neg_tgl <= ~ev.neg_tgl;
			end
		end
	end
endmodule

// [hdl/dsrp_link_if.sv]
`timescale 1ns/1ns
interface dsrp_link_if;
	logic pos_tgl;
	logic neg_tgl;
	modport src (output pos_tgl, output neg_tgl);
	modport dst (input pos_tgl, input neg_tgl);
endinterface

// [hdl/dsrp_pkg.sv]
package dsrp_pkg;

	// ----------------------------------------
	// Address width per word width
	// ----------------------------------------
	localparam int ADDR_W_X9 = 23;
	localparam int ADDR_W_X18 = 22;
	localparam int ADDR_W_X36 = 21;
	localparam int WORD_W_DEF = 36;

	// ----------------------------------------
	// Read latency in half cycles of the input clock pair
	// ----------------------------------------
	localparam logic [1:0] LAT_PLL_HALF = 2'h3;
	localparam logic [1:0] LAT_BYPASS_HALF = 2'h2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic PHASE_RST = 1'b0;
	localparam logic OE_RST = 1'b0;
	localparam logic ECHO_POS_RST = 1'b0;
	localparam logic ECHO_NEG_RST = 1'b1;

	typedef enum logic [3:0] {
		st_idle = 4'h1,
		st_word0 = 4'h2,
		st_word1 = 4'h4,
		st_drain = 4'h8
	} dsrp_state_t;

endpackage

// [hdl/dsrp_sync.sv]
`timescale 1ns/1ns
module dsrp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] ff1_reg;
	logic [W-1:0] ff2_reg;
	logic [W-1:0] ff3_reg;

	always_ff @(posedge clk) begin
		ff1_reg <= din;
		ff2_reg <= ff1_reg;
		ff3_reg <= ff2_reg;
	end

	// Change accepted only once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dout <= '0;
		end else if (ff2_reg == ff3_reg) begin
			dout <= ff3_reg;
		end
	end
endmodule

// [hdl/dsrp_top.sv]
`timescale 1ns/1ns
// What this block does
// - Read address taken on positive input clock, write address on negative.
// - Address width 23, 22 or 21 bits for 9, 18, 36-bit words.
// - Address ignored at an edge whose port is deselected.
// - Read data launched on output clock pair, or input pair in single mode.
// - Read data bus released whenever the read port is idle.
// - Active-low read select sampled on positive input clock starts a read.
// - On deselect, pending read completes, then drivers off after next positive output edge, or positive input edge in single mode.
// - Each read is a burst of two words from one location.
// - Every access starts on a positive input clock edge.
// - Negative input clock edge captures inputs and launches data in single mode.
// - Free-running echo strobes follow the positive and negative output clocks.
// - In single clock mode echo strobes follow the input clock pair.
// - Active-low write select on positive input clock starts a write.
// - Write data taken one word per input clock edge.
// - Bypassed loop gives the older one-cycle latency mode, 167 MHz at most.
module dsrp_top #(
	parameter int WORD_W = dsrp_pkg::WORD_W_DEF,
	parameter int MEM_AW = 4
) (
	// Core clock: one edge per half cycle of the input clock pair
	input wire logic clk,
	input wire logic rst_n,
	// Output clock pair: one edge per half cycle
	input wire logic link_clk,
	// Request pins, synchronous to clk
	input wire logic [(WORD_W == 9 ? dsrp_pkg::ADDR_W_X9 : (WORD_W == 18 ? dsrp_pkg::ADDR_W_X18 :
		dsrp_pkg::ADDR_W_X36))-1:0] addr_bus,
	input wire logic read_port_select_n,
	input wire logic write_port_select_n,
	input wire logic [WORD_W-1:0] wdata,
	// Static mode pins
	input wire logic pll_bypass_n,
	input wire logic single_clk_mode,
	// Read data and echo strobes
	output logic [WORD_W-1:0] q_out,
	output logic q_oe,
	output logic echo_strobe_pos,
	output logic echo_strobe_neg,
	// High while the next clk edge is a negative input clock edge
	output logic kneg_phase
);
	localparam int ADDR_W = (WORD_W == 9) ? dsrp_pkg::ADDR_W_X9 :
		(WORD_W == 18) ? dsrp_pkg::ADDR_W_X18 : dsrp_pkg::ADDR_W_X36;
	localparam int DEPTH = 1 << MEM_AW;

	dsrp_link_if link_ev ();
	logic [1:0] tgl_sync;
	logic [1:0] mode_sync;
	logic [1:0] tgl_prev_reg;
	logic c_pos_ev;
	logic c_neg_ev;
	logic single_mode;
	logic pll_on;
	logic k_edge;
	logic launch_ev;
	logic drain_ev;
	logic rd_start;
	logic hold_ready;
	logic take;
	logic [2*WORD_W-1:0] mem_reg [DEPTH];
	logic [MEM_AW-1:0] rd_idx;
	logic [MEM_AW-1:0] wr_idx;
	logic wr_arm_reg;
	logic [WORD_W-1:0] wr_w0_reg;
	logic hold_valid_reg;
	logic [1:0] hold_lat_reg;
	logic [2*WORD_W-1:0] hold_data_reg;
	logic [2*WORD_W-1:0] act_data_reg;
	dsrp_pkg::dsrp_state_t state_reg;

	// ----------------------------------------
	// Link edges and static pins into the core domain
	// ----------------------------------------
	dsrp_link u_link (
		.link_clk(link_clk),
		.rst_n(rst_n),
		.ev(link_ev.src)
	);

	dsrp_sync #(.W(2)) u_tgl_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din({link_ev.neg_tgl, link_ev.pos_tgl}),
		.dout(tgl_sync)
	);

	dsrp_sync #(.W(2)) u_mode_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din({single_clk_mode, pll_bypass_n}),
		.dout(mode_sync)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tgl_prev_reg <= 2'h0;
		end else begin
			tgl_prev_reg <= tgl_sync;
		end
	end

	assign c_pos_ev = tgl_sync[0] ^ tgl_prev_reg[0];
	assign c_neg_ev = tgl_sync[1] ^ tgl_prev_reg[1];
	assign single_mode = mode_sync[1];
	assign pll_on = mode_sync[0];

	// ----------------------------------------
	// Input clock pair phase
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			kneg_phase <= dsrp_pkg::PHASE_RST;
		end else begin
			kneg_phase <= ~kneg_phase;
		end
	end

	assign k_edge = ~kneg_phase;
	assign rd_start = k_edge && !read_port_select_n;
	assign launch_ev = single_mode ? 1'b1 : (c_pos_ev | c_neg_ev);
	assign drain_ev = single_mode ? k_edge : c_pos_ev;
	assign hold_ready = hold_valid_reg && (hold_lat_reg == 2'h0);
	assign rd_idx = addr_bus[MEM_AW-1:0];
	assign wr_idx = addr_bus[MEM_AW-1:0];

	always_comb begin
		take = 1'b0;
		case (state_reg)
			dsrp_pkg::st_idle: take = hold_ready;
			dsrp_pkg::st_word1: take = hold_ready && launch_ev;
			dsrp_pkg::st_drain: take = hold_ready;
			default: take = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Write port: first word on positive edge, address and second word on negative
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_arm_reg <= 1'b0;
			wr_w0_reg <= '0;
		end else if (k_edge) begin
			wr_arm_reg <= !write_port_select_n;
			if (!write_port_select_n) begin
				wr_w0_reg <= wdata;
			end
		end else begin
			wr_arm_reg <= 1'b0;
		end
	end

	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_mem
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					mem_reg[i] <= '0;
				end else if (!k_edge && wr_arm_reg && wr_idx == MEM_AW'(i)) begin
					mem_reg[i] <= {wdata, wr_w0_reg};
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Read capture and latency count
	// ----------------------------------------
	// One waiting read only; a read arriving while it is full and not taken is dropped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_valid_reg <= 1'b0;
			hold_lat_reg <= 2'h0;
			hold_data_reg <= '0;
		end else if (rd_start && (!hold_valid_reg || take)) begin
			hold_valid_reg <= 1'b1;
			hold_data_reg <= mem_reg[rd_idx];
			hold_lat_reg <= pll_on ? dsrp_pkg::LAT_PLL_HALF - 2'h1 : dsrp_pkg::LAT_BYPASS_HALF - 2'h1;
		end else if (take) begin
			hold_valid_reg <= 1'b0;
		end else if (hold_valid_reg && hold_lat_reg != 2'h0) begin
			hold_lat_reg <= hold_lat_reg - 2'h1;
		end
	end

	// ----------------------------------------
	// Burst launch and driver release
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= dsrp_pkg::st_idle;
			act_data_reg <= '0;
		end else begin
			if (take) begin
				act_data_reg <= hold_data_reg;
			end
			case (state_reg)
				dsrp_pkg::st_idle: begin
					if (take) begin
						state_reg <= dsrp_pkg::st_word0;
					end
				end
				dsrp_pkg::st_word0: begin
					if (launch_ev) begin
						state_reg <= dsrp_pkg::st_word1;
					end
				end
				dsrp_pkg::st_word1: begin
					if (launch_ev) begin
						state_reg <= take ? dsrp_pkg::st_word0 : dsrp_pkg::st_drain;
					end
				end
				dsrp_pkg::st_drain: begin
					if (take) begin
						state_reg <= dsrp_pkg::st_word0;
					end else if (drain_ev) begin
						state_reg <= dsrp_pkg::st_idle;
					end
				end
				default: state_reg <= dsrp_pkg::st_idle;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q_out <= '0;
			q_oe <= dsrp_pkg::OE_RST;
		end else if (state_reg == dsrp_pkg::st_word0 && launch_ev) begin
			q_out <= act_data_reg[WORD_W-1:0];
			q_oe <= 1'b1;
		end else if (state_reg == dsrp_pkg::st_word1 && launch_ev) begin
			q_out <= act_data_reg[2*WORD_W-1:WORD_W];
		end else if (state_reg == dsrp_pkg::st_drain && !take && drain_ev) begin
			q_oe <= 1'b0;
		end
	end

	// ----------------------------------------
	// Echo strobes
	// ----------------------------------------
	// Outputs kept on the core clock so that every pin leaves from one flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			echo_strobe_pos <= dsrp_pkg::ECHO_POS_RST;
			echo_strobe_neg <= dsrp_pkg::ECHO_NEG_RST;
		end else if (single_mode) begin
			echo_strobe_pos <= k_edge;
			echo_strobe_neg <= ~k_edge;
		end else if (c_pos_ev) begin
			echo_strobe_pos <= 1'b1;
			echo_strobe_neg <= 1'b0;
		end else if (c_neg_ev) begin
			echo_strobe_pos <= 1'b0;
			echo_strobe_neg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_PHASE_ALT: assert property ($past(rst_n) |-> kneg_phase != $past(kneg_phase))
		else $error("input clock phase did not alternate");
	AST_READ_CAPTURE: assert property (rd_start && !hold_valid_reg |=> hold_valid_reg)
		else $error("selected read not captured");
	AST_DESELECT_IGNORED: assert property ((!k_edge || read_port_select_n) && !hold_valid_reg |=> !hold_valid_reg)
		else $error("read captured while deselected or on negative edge");
	AST_LATENCY: assert property (rd_start && !hold_valid_reg && pll_on |=> hold_lat_reg == 2'h2 ##1 hold_lat_reg == 2'h1)
		else $error("read latency count wrong");
	AST_OE_IDLE: assert property (state_reg == dsrp_pkg::st_idle |-> !q_oe)
		else $error("driver enabled while idle");
	AST_BURST_TWO: assert property (state_reg == dsrp_pkg::st_word0 && launch_ev |=> state_reg == dsrp_pkg::st_word1)
		else $error("burst did not proceed to second word");
	AST_WORD0_OUT: assert property (state_reg == dsrp_pkg::st_word0 && launch_ev |=>
		q_oe && q_out == $past(act_data_reg[WORD_W-1:0]))
		else $error("first word not launched");
	AST_DRAIN_OFF: assert property (state_reg == dsrp_pkg::st_drain && drain_ev && !take |=> !q_oe)
		else $error("driver not released after drain edge");
	AST_SINGLE_BURST: assert property (single_mode && state_reg == dsrp_pkg::st_word0 |=> q_oe ##1 q_oe)
		else $error("single mode burst lost driver");
	AST_ECHO_SINGLE: assert property (single_mode && k_edge |=> echo_strobe_pos && !echo_strobe_neg)
		else $error("single mode echo wrong");
	AST_ECHO_SINGLE_NEG: assert property (single_mode && !k_edge |=> !echo_strobe_pos && echo_strobe_neg)
		else $error("single mode negative echo wrong");
	AST_ECHO_LINK: assert property (!single_mode && c_pos_ev |=> echo_strobe_pos && !echo_strobe_neg)
		else $error("echo not following output clock");
	AST_ECHO_LINK_NEG: assert property (!single_mode && c_neg_ev && !c_pos_ev |=> !echo_strobe_pos)
		else $error("echo not following negative output clock");
	AST_WRITE_ARM: assert property (k_edge && !write_port_select_n |=> wr_arm_reg ##1 !wr_arm_reg)
		else $error("write not armed for one half cycle");

	COV_READ: cover property (state_reg == dsrp_pkg::st_word0 ##[1:200] state_reg == dsrp_pkg::st_word1);
	COV_DRAIN: cover property (state_reg == dsrp_pkg::st_drain ##1 state_reg == dsrp_pkg::st_idle);
	COV_BACK_TO_BACK: cover property (state_reg == dsrp_pkg::st_word1 && take);
	COV_WRITE: cover property (wr_arm_reg && !k_edge);
	COV_BYPASS_READ: cover property (!pll_on && rd_start && !hold_valid_reg);
endmodule

// [verif/dsrp_ctrl_model.sv]
`timescale 1ns/1ns
// ----
// Controller: output clock pair
// ----
// One wire carries both phases so the pair never drifts apart;
// runs free because the echo strobes must run free
module dsrp_ctrl_model #(
	parameter int HALF_NS = 32
) (
	output logic link_clk
);
	initial begin
		link_clk = 1'b0;
		#7;
		forever #HALF_NS link_clk = ~link_clk;
	end
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ns
module testbench;
	typedef struct {
		logic [35:0] w0;
		logic [35:0] w1;
		int cyc;
	} dsrp_note_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic link_clk;
	logic [20:0] addr_bus = '0;
	logic read_port_select_n = 1'b1;
	logic write_port_select_n = 1'b1;
	logic [35:0] wdata = '0;
	logic pll_bypass_n = 1'b1;
	logic single_clk_mode = 1'b1;
	logic [35:0] q_out;
	logic q_oe, echo_strobe_pos, echo_strobe_neg, kneg_phase;
	logic [35:0] mem0 [16];
	logic [35:0] mem1 [16];
	dsrp_note_t notes [$];
	int cyc = 0;
	int error_cnt = 0;
	int checks = 0;
	int lat = 4;

	always #2 clk = ~clk;

	dsrp_ctrl_model ctrl (.link_clk(link_clk));
	dsrp_top #(.WORD_W(36), .MEM_AW(4)) uut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
		.addr_bus(addr_bus), .read_port_select_n(read_port_select_n),
		.write_port_select_n(write_port_select_n), .wdata(wdata), .pll_bypass_n(pll_bypass_n),
		.single_clk_mode(single_clk_mode), .q_out(q_out), .q_oe(q_oe),
		.echo_strobe_pos(echo_strobe_pos), .echo_strobe_neg(echo_strobe_neg), .kneg_phase(kneg_phase));

	// ----
	// Checking and closing
	// ----
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			error_cnt++;
			finish_test();
		end
	end

	// ----
	// Drivers, all on the falling edge
	// ----
	task automatic k_edge;
		do @(negedge clk); while (kneg_phase !== 1'b0);
	endtask

	task automatic do_reset(input logic pll, input logic sgl);
		@(negedge clk);
		rst_n = 1'b0;
		pll_bypass_n = pll;
		single_clk_mode = sgl;
		// Long enough for three link edges
		repeat (50) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask

	// Read select is also driven low on the K# edge, where it must be ignored
	task automatic do_write(input logic [20:0] a, input logic [35:0] w0, w1, input logic sel_n);
		k_edge();
		write_port_select_n = sel_n;
		wdata = w0;
		addr_bus = 21'($urandom);
		@(negedge clk);
		write_port_select_n = 1'b1;
		read_port_select_n = 1'b0;
		addr_bus = a;
		wdata = w1;
		@(negedge clk);
		read_port_select_n = 1'b1;
		wdata = 36'($urandom);
		if (!sel_n) begin
			mem0[a[3:0]] = w0;
			mem1[a[3:0]] = w1;
		end
	endtask

	task automatic do_read(input logic [20:0] a);
		dsrp_note_t n;
		k_edge();
		read_port_select_n = 1'b0;
		addr_bus = a;
		n.w0 = mem0[a[3:0]];
		n.w1 = mem1[a[3:0]];
		n.cyc = cyc + 1;
		notes.push_back(n);
		@(negedge clk);
		read_port_select_n = 1'b1;
		addr_bus = 21'($urandom);
		// Linked mode drops reads closer than about 128 ns
		repeat (80) @(negedge clk);
	endtask

	task automatic echo_check;
		int rises;
		logic prev;
		rises = 0;
		prev = echo_strobe_pos;
		repeat (320) begin
			@(negedge clk);
			chk(echo_strobe_neg, !echo_strobe_pos);
			if (single_clk_mode) begin
				chk(echo_strobe_pos, kneg_phase);
			end
			if (echo_strobe_pos === 1'b1 && prev === 1'b0) begin
				rises++;
			end
			prev = echo_strobe_pos;
		end
		chk(single_clk_mode ? (rises >= 159 && rises <= 160) : (rises >= 9 && rises <= 11), 1'b1);
	endtask

	// ----
	// Output monitor
	// ----
	initial begin
		dsrp_note_t n;
		int k;
		forever begin
			@(negedge clk);
			if (q_oe === 1'b1 && rst_n === 1'b1) begin
				if (notes.size() == 0) begin
					chk(1'b1, 1'b0);
				end else begin
					n = notes.pop_front();
					if (single_clk_mode) begin
						chk(cyc - n.cyc, lat);
					end
					chk(q_out, n.w0);
					k = 0;
					while (q_out === n.w0 && k < 40) begin
						@(negedge clk);
						k++;
					end
					chk(q_out, n.w1);
				end
				k = 0;
				while (q_oe !== 1'b0 && k < 80) begin
					@(negedge clk);
					k++;
				end
				chk(q_oe, 1'b0);
			end
		end
	end

	// ----
	// Main sequence: every latency and clocking mode
	// ----
	initial begin
		logic [20:0] a;
		void'($urandom(17446));
		repeat (16) @(negedge clk);
		for (int m = 0; m < 4; m++) begin
			lat = m[0] ? 4 : 3;
			do_reset(m[0], m[1]);
			for (int i = 0; i < 16; i++) begin
				do_write({17'($urandom), 4'(i)}, 36'($urandom), 36'($urandom), 1'b0);
			end
			a = 21'($urandom);
			do_write(a, 36'($urandom), 36'($urandom), 1'b1);
			do_read(a);
			for (int i = 0; i < 4; i++) begin
				do_read(21'($urandom));
			end
			echo_check();
		end
		finish_test();
	end
endmodule
